//--- hdl/pme_events.sv
// Event selection and counting for core demotion and frequency-band residency.
// Assumes power-control inputs are on mclk; Avalon-MM slave on mclk.
`timescale 1ns/10ps

// Notes on behaviour
// - A selected core's demotion pulse adds one to the counter, at most one per cycle.
// - Select 0x1f means core 1 demotions and 0x20 to 0x25 mean cores 2 to 7 in order.
// - Select 0x40 to 0x46 mean demotions of cores 8 to 14 in order.
// - A band event counts each cycle with the uncore frequency at or above its threshold.
// - Four independent bands are chosen by codes 0x0b to 0x0e.
// - Band n takes its threshold from byte n of the 32-bit filter register.
// - With edge detect a band event counts only false-to-true changes of its condition.
// - With inversion a band event counts cycles below the threshold.
// - Every event works on each of the four counters, so all bands can run at once.
// - Written control and threshold values take effect only at a frequency/voltage change pulse.
// - Without any frequency or voltage change the old comparison settings are kept.
// - Cycles in the middle of a frequency transition count in no band.
module pme_events
    import pme_pkg::*;
#(
    parameter int unsigned NCTR = NUM_CTR,
    parameter int unsigned CW   = CTR_W
) (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [3:0]          avs_byteenable,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [NUM_CORE-1:0] core_demotion,
    input  wire logic [7:0]          uncore_freq,
    input  wire logic                freq_in_transition,
    input  wire logic                freq_voltage_change,
    output logic      [NCTR*CW-1:0]  counter_values
);

    typedef struct packed {
        logic [NCTR-1:0][31:0]  ctl_shadow;
        logic [31:0]            filter_shadow;
        logic [NCTR-1:0][31:0]  ctl_live;
        logic [31:0]            filter_live;
        logic [NCTR-1:0][CW-1:0] count;
        logic [NCTR-1:0]        prev_cond;
        logic                   ack;
        logic [31:0]            rdata;
        logic [7:0]             apply_cnt;
    } pme_state_s;

    pme_state_s  st_q;
    pme_state_s  st_d;
    pme_ctl_s    ctl    [NCTR];
    logic [NCTR-1:0] inc;
    logic [NCTR-1:0] cond;
    logic [3:0]  band_ge;
    logic [5:0]  req_addr;
    logic        req;

    assign req = (avs_read || avs_write) && !st_q.ack;
    assign req_addr = avs_address;

    // Band comparisons against the applied thresholds
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_band
            assign band_ge[gb] = uncore_freq >= st_q.filter_live[gb*8 +: 8];
        end
    endgenerate

    genvar gc;
    generate
        for (gc = 0; gc < NCTR; gc++) begin : g_ctr
            logic [7:0] ev;
            logic       dem_hit;
            logic       band_hit;
            logic       band_cond;
            logic [3:0] core_idx;
            logic [1:0] band_idx;

            assign ctl[gc].event_sel = st_q.ctl_live[gc][CTL_EV_LSB +: 8];
            assign ctl[gc].edge_det  = st_q.ctl_live[gc][CTL_EDGE_BIT];
            assign ctl[gc].invert    = st_q.ctl_live[gc][CTL_INV_BIT];
            assign ctl[gc].enable    = st_q.ctl_live[gc][CTL_EN_BIT];
            assign ev = ctl[gc].event_sel;

            always_comb begin
                core_idx = 4'h0;
                dem_hit  = 1'b0;
                if (ev == EV_DEM_CORE1) begin
                    core_idx = 4'h1;
                    dem_hit  = 1'b1;
                end else if (ev >= EV_DEM_LO_FIRST && ev <= EV_DEM_LO_LAST) begin
                    core_idx = CORE_LO_BASE + 4'(ev - EV_DEM_LO_FIRST);
                    dem_hit  = 1'b1;
                end else if (ev >= EV_DEM_HI_FIRST && ev <= EV_DEM_HI_LAST) begin
                    core_idx = CORE_HI_BASE + 4'(ev - EV_DEM_HI_FIRST);
                    dem_hit  = 1'b1;
                end
            end

            assign band_hit  = (ev >= EV_BAND_FIRST) && (ev <= EV_BAND_LAST);
            assign band_idx  = 2'(ev - EV_BAND_FIRST);
            // Mid-transition cycles qualify in no band, inverted or not
            assign band_cond = !freq_in_transition
                               && (band_ge[band_idx] ^ ctl[gc].invert);
            assign cond[gc]  = band_hit && band_cond;

            always_comb begin
                inc[gc] = 1'b0;
                if (ctl[gc].enable) begin
                    if (dem_hit) begin
                        inc[gc] = core_demotion[core_idx];
                    end else if (band_hit) begin
                        inc[gc] = ctl[gc].edge_det ? (cond[gc] && !st_q.prev_cond[gc])
                                                   : cond[gc];
                    end
                end
            end

            assign counter_values[gc*CW +: CW] = st_q.count[gc];
        end
    endgenerate

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [CW-1:0] cv;
        logic [5:0]    rel;
        cv  = '0;
        rel = '0;
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.prev_cond = cond;
        for (int i = 0; i < NCTR; i++) begin
            if (inc[i]) begin
                st_d.count[i] = st_q.count[i] + CW'(1);
            end
        end
        // Shadow settings become live only on a frequency/voltage change
        if (freq_voltage_change) begin
            st_d.ctl_live    = st_q.ctl_shadow;
            st_d.filter_live = st_q.filter_shadow;
            st_d.apply_cnt   = st_q.apply_cnt + 8'h01;
        end
        if (req) begin
            st_d.ack   = 1'b1;
            st_d.rdata = UNMAPPED_VAL;
            if (req_addr < OFS_FILTER && req_addr[1:0] == 2'b00) begin
                if (avs_write) begin
                    st_d.ctl_shadow[req_addr[3:2]] =
                        merge_be(st_q.ctl_shadow[req_addr[3:2]], avs_writedata, avs_byteenable);
                end
                st_d.rdata = st_q.ctl_shadow[req_addr[3:2]];
            end else if (req_addr == OFS_FILTER) begin
                if (avs_write) begin
                    st_d.filter_shadow =
                        merge_be(st_q.filter_shadow, avs_writedata, avs_byteenable);
                end
                st_d.rdata = st_q.filter_shadow;
            end else if (req_addr >= OFS_CNT0_LO && req_addr < OFS_STATUS) begin
                rel = req_addr - OFS_CNT0_LO;
                cv  = st_q.count[rel[4:3]];
                st_d.rdata = rel[2] ? 32'(cv[CW-1:32]) : cv[31:0];
            end else if (req_addr == OFS_STATUS) begin
                st_d.rdata = {16'h0000, st_q.apply_cnt, 3'b000, freq_in_transition, cond};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q.ctl_shadow    <= {NCTR{CTL_RESET}};
            st_q.filter_shadow <= FILTER_RESET;
            st_q.ctl_live      <= {NCTR{CTL_RESET}};
            st_q.filter_live   <= FILTER_RESET;
            st_q.count         <= '0;
            st_q.prev_cond     <= '0;
            st_q.ack           <= 1'b0;
            st_q.rdata         <= 32'h0000_0000;
            st_q.apply_cnt     <= 8'h00;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign avs_waitrequest = !st_q.ack;
    assign avs_readdata    = st_q.rdata;

endmodule // pme_events

//--- hdl/pme_pkg.sv
// Package for the power-unit demotion and frequency-band event counters.
// Assumes a single clock domain and an Avalon-MM register slave.
package pme_pkg;

    localparam int unsigned NUM_CTR       = 4;
    localparam int unsigned NUM_CORE      = 15;
    localparam int unsigned CTR_W         = 48;

    // Event select codes
    localparam logic [7:0] EV_BAND_FIRST  = 8'h0b;
    localparam logic [7:0] EV_BAND_LAST   = 8'h0e;
    localparam logic [7:0] EV_DEM_CORE1   = 8'h1f;
    localparam logic [7:0] EV_DEM_LO_FIRST = 8'h20;
    localparam logic [7:0] EV_DEM_LO_LAST = 8'h25;
    localparam logic [7:0] EV_DEM_HI_FIRST = 8'h40;
    localparam logic [7:0] EV_DEM_HI_LAST = 8'h46;
    localparam logic [3:0] CORE_LO_BASE   = 4'h2;
    localparam logic [3:0] CORE_HI_BASE   = 4'h8;

    // Control register fields
    localparam int unsigned CTL_EV_LSB    = 0;
    localparam int unsigned CTL_EDGE_BIT  = 18;
    localparam int unsigned CTL_EN_BIT    = 22;
    localparam int unsigned CTL_INV_BIT   = 23;

    // Word byte offsets
    localparam logic [5:0] OFS_CTL0       = 6'h00;
    localparam logic [5:0] OFS_FILTER     = 6'h10;
    localparam logic [5:0] OFS_CNT0_LO    = 6'h14;
    localparam logic [5:0] OFS_STATUS     = 6'h34;

    localparam logic [31:0] CTL_RESET     = 32'h0000_0000;
    localparam logic [31:0] FILTER_RESET  = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_VAL  = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] event_sel;
        logic       edge_det;
        logic       invert;
        logic       enable;
    } pme_ctl_s;

    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } pme_avm_req_s;

endpackage

//--- tb/pme_events_bench.sv
// Bench for pme_events: integer mirror of settings and counters, checked each cycle.
`timescale 1ns/10ps
module pme_events_bench;
    import pme_pkg::*;
    localparam logic [127:0] CODES = 128'h3f264645_44434241_40252423_2221201f;
    logic               mclk = 1'b0;
    logic               reset = 1'b1;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic               start = 1'b0;
    logic [5:0]         avs_address = '0;
    logic [31:0]        avs_writedata = '0;
    logic [7:0]         target = '0;
    logic [3:0]         len = '0;
    logic [14:0]        core_demotion = '0;
    logic [31:0]        avs_readdata, sh[5], lv[5], filt;
    logic               avs_waitrequest, freq_in_transition, freq_voltage_change;
    logic [7:0]         uncore_freq;
    logic [4*CTR_W-1:0] counter_values;
    longint             ex[4];
    bit                 pc[4];
    int                 num_errors = 0;
    int                 n_checks = 0;
    int                 n_tr = 0;
    pme_events DUT (.mclk, .reset, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest,
        .core_demotion, .uncore_freq, .freq_in_transition, .freq_voltage_change,
        .counter_values);
    pme_power_model u_power (.mclk, .reset, .start, .target, .len, .uncore_freq,
        .freq_in_transition, .freq_voltage_change);
    always #5 mclk = ~mclk;
    always @(posedge mclk) core_demotion <= 15'($urandom & $urandom);
    // Previous band condition is tracked every cycle, enabled or not
    function automatic int inc(int i);
        int s = lv[i][7:0];
        int b, c, r;
        c = 0;
        r = 0;
        if (s >= 'h0b && s <= 'h0e) begin
            b = lv[4][(s - 'h0b) * 8 +: 8];
            c = !freq_in_transition && ((uncore_freq >= b) != lv[i][CTL_INV_BIT]);
            r = lv[i][CTL_EDGE_BIT] ? (c && !pc[i]) : c;
        end
        if (s >= 'h1f && s <= 'h25) r = core_demotion[s - 'h1e];
        if (s >= 'h40 && s <= 'h46) r = core_demotion[s - 'h38];
        pc[i] = c;
        return lv[i][CTL_EN_BIT] ? r : 0;
    endfunction
    always @(posedge mclk)
        if (reset) begin
            foreach (ex[i]) ex[i] = 0;
            foreach (pc[i]) pc[i] = 1'b0;
            foreach (lv[i]) lv[i] = '0;
            sh = lv;
        end else begin
            foreach (ex[i]) ex[i] += inc(i);
            if (freq_voltage_change) lv = sh;
        end
    task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(negedge mclk)
        if (!reset)
            foreach (ex[i]) chk("counter", 48'(ex[i]), counter_values[i*CTR_W+:CTR_W]);
    task automatic finish_test(bit hang);
        if (hang) num_errors++;
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(bit w, logic [5:0] a, logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) finish_test(1'b1);
        q = avs_readdata;
        if (w && a <= OFS_FILTER) sh[a[4:2]] = d;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic prog(logic [31:0] c, bit inv, bit edg);
        logic [31:0] q;
        for (int i = 0; i < 4; i++)
            bus(1'b1, 6'(4 * i), {8'h0, inv, 1'b1, 3'h0, edg, 10'h0, c[i*8+:8]}, q);
    endtask
    task automatic trans();
        int k;
        @(posedge mclk);
        target <= ($urandom % 2) ? filt[8 * ($urandom % 4) +: 8] : 8'($urandom);
        len <= 4'($urandom);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        for (k = 0; k < 40 && freq_voltage_change !== 1'b1; k++) @(posedge mclk);
        if (k == 40) finish_test(1'b1);
        n_tr++;
        repeat (10) @(posedge mclk);
    endtask
    initial begin
        logic [31:0] q;
        void'($urandom(32'hb53d03d6));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        prog(32'h0e0d0c0b, 1'b0, 1'b0);
        bus(1'b1, OFS_FILTER, 32'h80402010, q);
        repeat (30) @(posedge mclk);
        for (int r = 0; r < 3; r++) begin
            prog(32'h0e0d0c0b, r == 1, r == 2);
            filt = $urandom;
            bus(1'b1, OFS_FILTER, filt, q);
            repeat (8) trans();
        end
        for (int g = 0; g < 4; g++) begin
            prog(CODES[g*32+:32], 1'b0, 1'b0);
            trans();
        end
        prog(32'h0, 1'b0, 1'b0);
        trans();
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 6'(OFS_CNT0_LO + 8 * i), 32'h0, q);
            chk("count_lo", 48'(ex[i][31:0]), 48'(q));
            bus(1'b0, 6'(OFS_CNT0_LO + 8 * i + 4), 32'h0, q);
            chk("count_hi", 48'(ex[i][47:32]), 48'(q));
        end
        bus(1'b0, OFS_FILTER, 32'h0, q);
        chk("filter", 48'(sh[4]), 48'(q));
        bus(1'b0, OFS_CTL0, 32'h0, q);
        chk("ctl0", 48'(sh[0]), 48'(q));
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk("status", 48'({16'h0000, 8'(n_tr), 8'h00}), 48'(q));
        bus(1'b1, 6'h3c, 32'hffffffff, q);
        bus(1'b0, 6'h3c, 32'h0, q);
        chk("unmapped", 48'(UNMAPPED_VAL), 48'(q));
        finish_test(1'b0);
    end
endmodule // pme_events_bench

//--- tb/pme_events_sva.sv
// Checker on the ports of pme_events; bound below.
`timescale 1ns/10ps
module pme_events_sva
    import pme_pkg::*;
#(
    parameter int unsigned NCTR = NUM_CTR,
    parameter int unsigned CW   = CTR_W
) (
    input wire logic                mclk,
    input wire logic                reset,
    input wire logic                clk_en,
    input wire logic [5:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [NUM_CORE-1:0] core_demotion,
    input wire logic                freq_in_transition,
    input wire logic                freq_voltage_change,
    input wire logic [NCTR*CW-1:0]  counter_values
);
    logic applied_q;
    always_ff @(posedge mclk)
        applied_q <= !reset && (applied_q || (clk_en && freq_voltage_change));
    function automatic bit steps_ok(logic [NCTR*CW-1:0] a, logic [NCTR*CW-1:0] b);
        bit ok = 1'b1;
        for (int i = 0; i < NCTR; i++) ok &= (a[i*CW+:CW] - b[i*CW+:CW]) <= 1;
        return ok;
    endfunction
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_ack_one_cycle: assert property (clk_en && !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_req_answered: assert property (clk_en && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered next cycle");
    a_idle_no_ack: assert property (clk_en && avs_waitrequest && !(avs_read || avs_write)
        |=> avs_waitrequest) else $error("answer without request");
    a_step_at_most: assert property (clk_en |=> steps_ok(counter_values, $past(counter_values)))
        else $error("counter moved by more than one");
    a_trans_no_band: assert property (clk_en && freq_in_transition && core_demotion == '0
        |=> $stable(counter_values)) else $error("count during transition");
    a_hold_unapplied: assert property (!applied_q |-> counter_values == '0)
        else $error("count before settings applied");
    a_reset_state: assert property (disable iff (1'b0) clk_en && reset
        |=> avs_waitrequest && counter_values == '0) else $error("bad reset state");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h34
        |-> avs_readdata == '0) else $error("unmapped read not zero");
    c_apply: cover property (freq_voltage_change);
    c_read_ack: cover property (avs_read && !avs_waitrequest);
    c_count_up: cover property (counter_values != $past(counter_values));
endmodule // pme_events_sva
bind pme_events pme_events_sva #(.NCTR(NCTR), .CW(CW)) u_sva (.mclk, .reset, .clk_en,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .core_demotion,
    .freq_in_transition, .freq_voltage_change, .counter_values);

//--- tb/pme_power_model.sv
// Partner model: power-control side that makes uncore frequency changes.
// Assumes the bench pulses start for one cycle and waits for the change pulse.
`timescale 1ns/10ps
module pme_power_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic [7:0] target,
    input  wire logic [3:0] len,
    output logic      [7:0] uncore_freq,
    output logic            freq_in_transition,
    output logic            freq_voltage_change
);
    logic [3:0] n;
    always @(posedge mclk) begin
        freq_voltage_change <= 1'b0;
        if (reset) begin
            freq_in_transition <= 1'b0;
            uncore_freq <= 8'h10;
        end else if (freq_in_transition) begin
            // Frequency is unsettled while it changes
            uncore_freq <= ~uncore_freq;
            n <= n - 4'h1;
            if (n == 4'h0) begin
                freq_in_transition <= 1'b0;
                uncore_freq <= target;
                freq_voltage_change <= 1'b1;
            end
        end else if (start) begin
            freq_in_transition <= 1'b1;
            n <= len;
        end
    end
endmodule // pme_power_model
